// ---- hw/tpei_cfg.svh ----
/*
 * offsets, field positions, widths and reset values of the payload error inserter.
 * assumes it is included by bare name wherever these constants are needed.
 */
`ifndef TPEI_CFG_SVH
`define TPEI_CFG_SVH

`define TPEI_ADDR_CTRL 12'h000
`define TPEI_ADDR_CNT_LO 12'h004
`define TPEI_ADDR_CNT_HI 12'h008
`define TPEI_ADDR_CHAN 12'h00C
`define TPEI_ADDR_CFG 12'h010

`define TPEI_CTRL_RATE_LSB 0
`define TPEI_CTRL_RATE_MSB 3
`define TPEI_CTRL_CONT 4
`define TPEI_CTRL_STROBE 7
`define TPEI_CFG_CHAN_MODE 0
`define TPEI_CFG_T1_MODE 1

`define TPEI_CNT_W 10
`define TPEI_CHAN_NUM 24
`define TPEI_RST_RATE 4'h0
`define TPEI_RST_CNT 10'h000
`define TPEI_RST_CHAN 24'h000000
`define TPEI_RST_BITCNT 16'h0000
`define TPEI_RST_DATA 32'h00000000

`endif

// ---- hw/tpei_pkg.sv ----
/*
 * types of the payload error inserter: the state record and the stream input bundle.
 * assumes tpei_cfg.svh is on the include path.
 */
`include "tpei_cfg.svh"

package tpei_pkg;

    typedef struct packed {
        logic bit_valid;
        logic data;
        logic framing_bit;
        logic frame_start;
        logic [4:0] channel;
    } tpei_stream_type;

    typedef struct packed {
        logic [3:0] rate_sel;
        logic cont;
        logic strobe;
        logic chan_mode;
        logic t1_mode;
        logic [`TPEI_CHAN_NUM-1:0] chan_en;
        logic [`TPEI_CNT_W-1:0] pend_cnt;
        logic [`TPEI_CNT_W-1:0] remain;
        logic [3:0] act_rate;
        logic [15:0] bit_cnt;
        logic data_out;
        logic valid_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tpei_state_type;

endpackage

// ---- hw/tpei_top.sv ----
/*
 * t1 transmit payload error inserter with an apb register slave.
 * assumes the framer presents one payload or framing bit per valid cycle on clk_in,
 * with frame_start marking the first bit of each frame and channel giving the time slot.
 */

`include "tpei_cfg.svh"

module tpei_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    input wire tpei_pkg::tpei_stream_type stream_in,
    output logic data_out,
    output logic data_valid_out
);

    tpei_pkg::tpei_state_type st_reg;
    tpei_pkg::tpei_state_type st_next;

    logic access;
    logic wr_fire;
    logic mapped;
    logic strobe_rise;
    logic eligible;
    logic [15:0] rate_n;
    logic [15:0] cnt_inc;
    logic flip;
    logic [31:0] rd_val;

    // apb transfer completes on the second access cycle
    assign access = psel_in & penable_in;
    assign wr_fire = access & st_reg.pready & pwrite_in;
    assign mapped = (paddr_in == `TPEI_ADDR_CTRL) || (paddr_in == `TPEI_ADDR_CNT_LO) ||
        (paddr_in == `TPEI_ADDR_CNT_HI) || (paddr_in == `TPEI_ADDR_CHAN) ||
        (paddr_in == `TPEI_ADDR_CFG);
    assign strobe_rise = wr_fire && (paddr_in == `TPEI_ADDR_CTRL) &&
        pwdata_in[`TPEI_CTRL_STROBE] && !st_reg.strobe;

    // rate code k selects one error in 2**k counted bits; code 0 inserts no errors
    assign rate_n = 16'h0001 << st_reg.act_rate;
    assign cnt_inc = st_reg.bit_cnt + 16'h0001;

    always_comb begin
        eligible = stream_in.bit_valid && !stream_in.framing_bit && st_reg.t1_mode;
        if (st_reg.chan_mode) begin
            eligible = eligible && (stream_in.channel < 5'(`TPEI_CHAN_NUM)) &&
                st_reg.chan_en[stream_in.channel];
        end
        if (st_reg.act_rate == 4'h0) begin
            eligible = 1'b0;
        end
        if (!st_reg.cont && (st_reg.remain == 10'h000)) begin
            eligible = 1'b0;
        end
    end

    // a rate lowered at a frame boundary can leave the count past the new limit
    assign flip = eligible && (cnt_inc >= rate_n);

    always_comb begin
        rd_val = 32'h00000000;
        case (paddr_in)
            `TPEI_ADDR_CTRL: begin
                rd_val[`TPEI_CTRL_RATE_MSB:`TPEI_CTRL_RATE_LSB] = st_reg.rate_sel;
                rd_val[`TPEI_CTRL_CONT] = st_reg.cont;
                rd_val[`TPEI_CTRL_STROBE] = st_reg.strobe;
            end
            `TPEI_ADDR_CNT_LO: begin
                rd_val[7:0] = st_reg.remain[7:0];
            end
            `TPEI_ADDR_CNT_HI: begin
                rd_val[1:0] = st_reg.remain[9:8];
            end
            `TPEI_ADDR_CHAN: begin
                rd_val[`TPEI_CHAN_NUM-1:0] = st_reg.chan_en;
            end
            `TPEI_ADDR_CFG: begin
                rd_val[`TPEI_CFG_CHAN_MODE] = st_reg.chan_mode;
                rd_val[`TPEI_CFG_T1_MODE] = st_reg.t1_mode;
            end
            default: begin
                rd_val = 32'h00000000;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // bus side
        st_next.pready = access & !st_reg.pready;
        if (access & !st_reg.pready) begin
            st_next.pslverr = !mapped;
            st_next.prdata = pwrite_in ? `TPEI_RST_DATA : rd_val;
        end else begin
            st_next.pslverr = 1'b0;
            st_next.prdata = `TPEI_RST_DATA;
        end
        // reserved bits are dropped on write
        if (wr_fire) begin
            case (paddr_in)
                `TPEI_ADDR_CTRL: begin
                    st_next.rate_sel = pwdata_in[`TPEI_CTRL_RATE_MSB:`TPEI_CTRL_RATE_LSB];
                    st_next.cont = pwdata_in[`TPEI_CTRL_CONT];
                    st_next.strobe = pwdata_in[`TPEI_CTRL_STROBE];
                end
                `TPEI_ADDR_CNT_LO: begin
                    st_next.pend_cnt[7:0] = pwdata_in[7:0];
                end
                `TPEI_ADDR_CNT_HI: begin
                    st_next.pend_cnt[9:8] = pwdata_in[1:0];
                end
                `TPEI_ADDR_CHAN: begin
                    st_next.chan_en = pwdata_in[`TPEI_CHAN_NUM-1:0];
                end
                `TPEI_ADDR_CFG: begin
                    st_next.chan_mode = pwdata_in[`TPEI_CFG_CHAN_MODE];
                    st_next.t1_mode = pwdata_in[`TPEI_CFG_T1_MODE];
                end
                default: begin
                    st_next.pend_cnt = st_reg.pend_cnt;
                end
            endcase
        end
        // stream side
        if (stream_in.bit_valid && stream_in.frame_start) begin
            st_next.act_rate = st_reg.rate_sel;
        end
        if (eligible) begin
            st_next.bit_cnt = flip ? `TPEI_RST_BITCNT : cnt_inc;
        end
        if (flip && !st_reg.cont) begin
            st_next.remain = st_reg.remain - 10'h001;
        end
        // a fresh load takes priority over a decrement in the same cycle
        if (strobe_rise) begin
            st_next.remain = st_reg.pend_cnt;
        end
        st_next.data_out = stream_in.data ^ flip;
        st_next.valid_out = stream_in.bit_valid;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg.rate_sel <= `TPEI_RST_RATE;
            st_reg.cont <= 1'b0;
            st_reg.strobe <= 1'b0;
            st_reg.chan_mode <= 1'b0;
            st_reg.t1_mode <= 1'b0;
            st_reg.chan_en <= `TPEI_RST_CHAN;
            st_reg.pend_cnt <= `TPEI_RST_CNT;
            st_reg.remain <= `TPEI_RST_CNT;
            st_reg.act_rate <= `TPEI_RST_RATE;
            st_reg.bit_cnt <= `TPEI_RST_BITCNT;
            st_reg.data_out <= 1'b0;
            st_reg.valid_out <= 1'b0;
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.prdata <= `TPEI_RST_DATA;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready_out = st_reg.pready;
    assign pslverr_out = st_reg.pslverr;
    assign prdata_out = st_reg.prdata;
    assign data_out = st_reg.data_out;
    assign data_valid_out = st_reg.valid_out;

    framing_intact_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (stream_in.bit_valid && stream_in.framing_bit) |=> (data_out == $past(stream_in.data))
    ) else $error("framing bit was altered");

    non_t1_pass_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !st_reg.t1_mode |=> (data_out == $past(stream_in.data))
    ) else $error("bit altered outside t1 mode");

    zero_rate_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (st_reg.act_rate == 4'h0) |=> (data_out == $past(stream_in.data))
    ) else $error("error made with rate select zero");

    rate_hold_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !(stream_in.bit_valid && stream_in.frame_start) |=> $stable(st_reg.act_rate)
    ) else $error("rate changed inside a frame");

    nth_bit_flip_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (eligible && (st_reg.bit_cnt == rate_n - 16'h0001)) |=>
            (data_out != $past(stream_in.data)) && (st_reg.bit_cnt == 16'h0000)
    ) else $error("nth counted bit not inverted");

    unselected_chan_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (st_reg.chan_mode && (stream_in.channel < 5'(`TPEI_CHAN_NUM)) &&
            !st_reg.chan_en[stream_in.channel]) |=> (data_out == $past(stream_in.data))
    ) else $error("unselected channel corrupted");

    strobe_load_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        strobe_rise |=> (st_reg.remain == $past(st_reg.pend_cnt))
    ) else $error("strobe edge did not load count");

    count_down_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (flip && !st_reg.cont && !strobe_rise) |=>
            (st_reg.remain == $past(st_reg.remain) - 10'h001)
    ) else $error("remaining count not decremented");

    burst_stop_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (!st_reg.cont && (st_reg.remain == 10'h000)) |=> (data_out == $past(stream_in.data))
    ) else $error("error inserted after burst ended");

    count_read_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (access && !st_reg.pready && !pwrite_in && (paddr_in == `TPEI_ADDR_CNT_LO)) |=>
            (pready_out && (prdata_out[7:0] == $past(st_reg.remain[7:0])))
    ) else $error("count read does not show remaining");

    apb_answer_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (access && !st_reg.pready) |=> pready_out ##1 !pready_out
    ) else $error("apb answer not one cycle after access");

    reset_clear_a: assert property (
        @(posedge clk_in)
        !nrst_in |=> (!pready_out && !pslverr_out && (prdata_out == 32'h00000000) &&
            !data_valid_out && !data_out)
    ) else $error("outputs not cleared by reset");

    no_stray_ready_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !(access && !st_reg.pready) |=> !pready_out
    ) else $error("ready raised without an access");

    slave_error_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (access && !st_reg.pready) |=> (pslverr_out != $past(mapped))
    ) else $error("error answer does not match address decode");

    write_data_zero_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (access && !st_reg.pready && pwrite_in) |=> (prdata_out == 32'h00000000)
    ) else $error("read data shown on a write");

    idle_bus_zero_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !pready_out |-> ((prdata_out == 32'h00000000) && !pslverr_out)
    ) else $error("bus outputs not zero outside an answer");

    cont_write_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (wr_fire && (paddr_in == `TPEI_ADDR_CTRL)) |=>
            (st_reg.cont == $past(pwdata_in[`TPEI_CTRL_CONT]))
    ) else $error("continuous bit not written");

    rate_write_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (wr_fire && (paddr_in == `TPEI_ADDR_CTRL)) |=>
            (st_reg.rate_sel == $past(pwdata_in[`TPEI_CTRL_RATE_MSB:`TPEI_CTRL_RATE_LSB]))
    ) else $error("rate select not written");

    pend_low_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (wr_fire && (paddr_in == `TPEI_ADDR_CNT_LO)) |=>
            (st_reg.pend_cnt[7:0] == $past(pwdata_in[7:0]))
    ) else $error("low count byte not written");

    pend_high_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (wr_fire && (paddr_in == `TPEI_ADDR_CNT_HI)) |=>
            (st_reg.pend_cnt[9:8] == $past(pwdata_in[1:0]))
    ) else $error("high count bits not written");

    count_high_read_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (access && !st_reg.pready && !pwrite_in && (paddr_in == `TPEI_ADDR_CNT_HI)) |=>
            ((prdata_out[1:0] == $past(st_reg.remain[9:8])) && (prdata_out[31:2] == 30'h00000000))
    ) else $error("high count read does not show remaining");

    reload_only_rise_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (wr_fire && (paddr_in == `TPEI_ADDR_CTRL) && st_reg.strobe && !flip) |=> $stable(st_reg.remain)
    ) else $error("count reloaded without a strobe edge");

    cont_hold_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (st_reg.cont && !strobe_rise) |=> $stable(st_reg.remain)
    ) else $error("remaining count moved in continuous mode");

    empty_hold_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (!st_reg.cont && (st_reg.remain == 10'h000) && !strobe_rise) |=> (st_reg.remain == 10'h000)
    ) else $error("remaining count left zero without a load");

    valid_follow_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        1'b1 |=> (data_valid_out == $past(stream_in.bit_valid))
    ) else $error("output valid does not follow input valid");

    framing_count_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (stream_in.bit_valid && stream_in.framing_bit) |=> $stable(st_reg.bit_cnt)
    ) else $error("framing bit advanced the bit counter");

    count_step_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (eligible && !flip) |=> (st_reg.bit_cnt == $past(cnt_inc))
    ) else $error("bit counter did not advance by one");

    early_bits_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (eligible && (cnt_inc < rate_n)) |=> (data_out == $past(stream_in.data))
    ) else $error("bit inverted before the end of the count");

    rate_adopt_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (stream_in.bit_valid && stream_in.frame_start) |=> (st_reg.act_rate == $past(st_reg.rate_sel))
    ) else $error("rate not adopted at frame boundary");

    idle_count_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (st_reg.act_rate == 4'h0) |=> $stable(st_reg.bit_cnt)
    ) else $error("bit counter moved with rate select zero");

    pass_through_a: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        (stream_in.bit_valid && !eligible) |=> (data_out == $past(stream_in.data))
    ) else $error("uncounted bit was altered");

endmodule // tpei_top

// ---- test/test_t1_payload_error_inserter.sv ----
/* self-checking bench of the payload error inserter: apb master, framer model, flip counter.
   assumes tpei_cfg.svh on the include path. */
`include "tpei_cfg.svh"
module test_t1_payload_error_inserter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h00000000;
    logic pready_out, pslverr_out, data_out, data_valid_out, er;
    logic [31:0] prdata_out, rd;
    tpei_pkg::tpei_stream_type stream, prev;
    int fails = 0, total_checks = 0, cycles = 0, flips = 0, fflips = 0, oflips = 0;
    always #20 clk_in = ~clk_in;
    tpei_framer_model i_model (.clk_in(clk_in), .nrst_in(nrst_in), .stream_out(stream));
    tpei_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .prdata_out(prdata_out), .stream_in(stream), .data_out(data_out),
        .data_valid_out(data_valid_out));
    // output bit compared with the input bit of the cycle before
    always @(posedge clk_in) begin
        prev <= stream;
        cycles <= cycles + 1;
        if (data_valid_out === 1'b1 && data_out !== prev.data) begin
            flips <= flips + 1;
            if (prev.framing_bit) fflips <= fflips + 1;
            if (prev.channel != 5'h00) oflips <= oflips + 1;
        end
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // pready, read data and error are taken at the rising edge that completes the access
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // counts flips over n frames; eo below zero skips the slot check
    task automatic frames(input int n, input int ef, input int eo);
        int b, bf, bo;
        @(negedge clk_in);
        b = flips;
        bf = fflips;
        bo = oflips;
        repeat (n * 193) @(negedge clk_in);
        chk(32'(flips - b), 32'(ef));
        chk(32'(fflips - bf), 32'h00000000);
        if (eo >= 0) chk(32'(oflips - bo), 32'(eo));
    endtask
    task automatic t_reset();
        apb(1'b0, `TPEI_ADDR_CTRL, 32'h0);
        chk(rd, 32'h00000000);
        chk({31'h0, er}, 32'h00000000);
        apb(1'b0, `TPEI_ADDR_CNT_LO, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h00000001);
        $display("test reset done");
    endtask
    task automatic t_rates();
        apb(1'b1, `TPEI_ADDR_CFG, 32'h00000002);
        for (int k = 1; k <= 4; k++) begin
            apb(1'b1, `TPEI_ADDR_CTRL, 32'h10 | k);
            repeat (200) @(posedge clk_in);
            frames(4, 768 >> k, -1);
        end
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000010);
        repeat (200) @(posedge clk_in);
        frames(2, 0, -1);
        apb(1'b1, `TPEI_ADDR_CFG, 32'h00000000);
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000011);
        frames(2, 0, -1);
        $display("test rates done");
    endtask
    task automatic t_chan();
        apb(1'b1, `TPEI_ADDR_CHAN, 32'h00000001);
        apb(1'b1, `TPEI_ADDR_CFG, 32'h00000003);
        repeat (200) @(posedge clk_in);
        frames(4, 16, 0);
        $display("test channels done");
    endtask
    task automatic t_burst();
        apb(1'b1, `TPEI_ADDR_CFG, 32'h00000000);
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000001);
        apb(1'b1, `TPEI_ADDR_CNT_LO, 32'h000000FF);
        apb(1'b1, `TPEI_ADDR_CNT_HI, 32'h00000003);
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000081);
        apb(1'b0, `TPEI_ADDR_CNT_LO, 32'h0);
        chk(rd, 32'h000000FF);
        apb(1'b0, `TPEI_ADDR_CNT_HI, 32'h0);
        chk(rd, 32'h00000003);
        apb(1'b1, `TPEI_ADDR_CNT_LO, 32'h00000002);
        apb(1'b1, `TPEI_ADDR_CNT_HI, 32'h00000000);
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000001);
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000081);
        apb(1'b0, `TPEI_ADDR_CNT_LO, 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b1, `TPEI_ADDR_CFG, 32'h00000002);
        frames(2, 2, -1);
        apb(1'b0, `TPEI_ADDR_CNT_LO, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b1, `TPEI_ADDR_CNT_LO, 32'h00000005);
        apb(1'b1, `TPEI_ADDR_CTRL, 32'h00000081);
        apb(1'b0, `TPEI_ADDR_CNT_LO, 32'h0);
        chk(rd, 32'h00000000);
        $display("test burst done");
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset();
        t_rates();
        t_chan();
        t_burst();
        tally_and_finish();
    end
endmodule // test_t1_payload_error_inserter

// ---- test/tpei_framer_model.sv ----
/* t1 transmit framer model: 193-bit frames, framing bit first, then 24 slots of 8 bits.
   assumes one bit per clk_in cycle and a restart on reset. */
module tpei_framer_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    output tpei_pkg::tpei_stream_type stream_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pos_reg;
    logic [6:0] lfsr_reg;
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            pos_reg <= 8'h00;
            lfsr_reg <= 7'h5A;
            stream_out <= '0;
        end else begin
            pos_reg <= (pos_reg == 8'hC0) ? 8'h00 : pos_reg + 8'h01;
            lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
            stream_out.bit_valid <= 1'b1;
            stream_out.data <= lfsr_reg[6];
            stream_out.framing_bit <= (pos_reg == 8'h00);
            stream_out.frame_start <= (pos_reg == 8'h00);
            stream_out.channel <= (pos_reg == 8'h00) ? 5'h00 : 5'((pos_reg - 8'h01) >> 3);
        end
    end
endmodule // tpei_framer_model
